// ===== design/pxp1_pkg.sv
package pxp1_pkg;

  // ==========================================================================
  // Management address map.
  localparam logic [4:0]  PAGE_SEL_ADDR    = 5'h1f;
  localparam logic [15:0] PAGE_MAIN        = 16'h0000;
  localparam logic [15:0] PAGE_EXT1        = 16'h0001;
  localparam logic [4:0]  UPPER_FIRST      = 5'h10;
  localparam logic [4:0]  UPPER_LAST       = 5'h1e;
  localparam logic [4:0]  FIBER_CTRL_ADDR  = 5'h10;
  localparam logic [4:0]  GOOD_CRC_ADDR    = 5'h12;
  localparam logic [4:0]  EXT_MODE_ADDR    = 5'h13;

  // ==========================================================================
  // APB byte offsets of the block's own registers.
  localparam logic [11:0] APB_MGMT_CMD     = 12'h000;
  localparam logic [11:0] APB_MGMT_RDATA   = 12'h004;
  localparam logic [11:0] APB_IRQ_STATUS   = 12'h008;
  localparam logic [11:0] APB_IRQ_MASK     = 12'h00c;
  localparam logic [11:0] APB_LINK_STATUS  = 12'h010;

  // ==========================================================================
  // Field positions and reset values.
  localparam int          TX_RF_HI         = 15;
  localparam int          TX_RF_LO         = 14;
  localparam int          LP_RF_HI         = 13;
  localparam int          LP_RF_LO         = 12;
  localparam int          ALLOW_1000X_BIT  = 9;
  localparam int          ALLOW_100FX_BIT  = 8;
  localparam int          FEF_BIT          = 6;
  localparam int          PKT_SEEN_BIT     = 15;
  localparam int          LED_EXT_HI       = 15;
  localparam int          LED_EXT_LO       = 12;
  localparam int          BLINK_BIT        = 11;
  localparam int          FLF_BIT          = 4;
  localparam int          XOVER_HI         = 3;
  localparam int          XOVER_LO         = 2;
  localparam int          SIGNAL_DETECT_INPUT_POL_BIT   = 0;
  localparam logic [15:0] FIBER_CTRL_WMASK = 16'hc300;
  localparam logic [15:0] EXT_MODE_WMASK   = 16'hf81d;
  localparam logic [15:0] FIBER_CTRL_RST   = 16'h0300;
  localparam logic [15:0] EXT_MODE_RST     = 16'h0000;
  localparam logic [13:0] CRC_MODULUS_LAST = 14'd9999;
  localparam int          FIBER_PORTS      = 4;
  localparam logic [2:0]  PORT_ID_RST      = 3'h0;

  // ==========================================================================
  // Interrupt status bits.
  localparam int          IRQ_FEF          = 0;
  localparam int          IRQ_PKT          = 1;
  localparam int          IRQ_WRAP         = 2;

  typedef enum logic [1:0] {
    PXP1_XOVER_AUTO,
    PXP1_XOVER_RSVD,
    PXP1_XOVER_MDI,
    PXP1_XOVER_MDIX
  } pxp1_xover_t;

  typedef struct packed {
    logic [3:0]  led_ext_mode;
    logic        reset_blink_en;
    logic        fast_link_fail_en;
    pxp1_xover_t crossover;
    logic        signal_detect_input_active_low;
    logic [1:0]  tx_remote_fault;
    logic        allow_1000x;
    logic        allow_100fx;
  } pxp1_cfg_t;

endpackage : pxp1_pkg

// ===== design/pxp1_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Writing 0x0001 to management address 31 selects extended page one for upper addresses.
// - Writing 0x0000 to address 31 returns upper addresses to the main register space.
// - With page one selected, addresses 16 to 30 reach the page-one registers.
// - Addresses 0 to 15 always reach the standard registers whatever page is selected.
// - Fiber control bits 15:14 are read/write, reset 00, and are sent out as local remote fault.
// - Fiber control bits 13:12 read back the far partner's remote-fault bits from negotiation.
// - Fiber control bit 9, reset 1, permits gigabit fiber link-up when set and suppresses it when clear.
// - Fiber control bit 8, reset 1, permits 100 Mb fiber link-up when set and suppresses it when clear.
// - Fiber control bit 6 is set by a 100 Mb far-end fault and cleared by reading the register.
// - Good-CRC register bit 15 is set by any good copper packet since the last read and cleared on read.
// - Good-CRC bits 13:0 count good copper packets modulo 10000, wrap after 9999 and clear on read.
// - Extended mode bits 15:12, reset 0, switch LED3 to LED0 into their extended display set.
// - Extended mode bit 11, reset 0, enables the LED blink when the sleep hold is released.
// - Extended mode bit 4 enables the fast link failure pin, else the pin is general-purpose I/O.
// - Extended mode bits 3:2 choose crossover: 00 automatic, 01 reserved, 10 forced MDI, 11 forced MDI-X.
// - Fiber control settings reach the permits and remote fault on ports 0 to 3 only; the cfg allow bits follow them on every port.
module pxp1_regs (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [2:0]          port_id,
  input  wire logic [1:0]          far_partner_remote_fault,
  input  wire logic                far_end_fault,
  input  wire logic                good_crc_packet,
  input  wire logic [1:0]          signal_detect_input,
  output logic [1:0]               signal_detect_seen,
  output pxp1_pkg::pxp1_cfg_t      cfg,
  output logic [15:0]              std_rdata_req,
  output logic                     fiber_1000x_permit,
  output logic                     fiber_100fx_permit,
  output logic                     irq
);
  import pxp1_pkg::*;

  // ==========================================================================
  // Synchronisers for asynchronous pins.
  logic [1:0] far_rf_s1_ff, far_rf_s2_ff;
  logic       fef_s1_ff, fef_s2_ff, fef_s3_ff;
  logic [1:0] sd_s1_ff, sd_s2_ff;
  // The port number is a strap and is synchronised like any pin. Until it has crossed both
  // flops the block assumes port 0, so a non-fiber port may show its permits for two cycles.
  logic [2:0] port_id_s1_ff, port_id_s2_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      far_rf_s1_ff <= 2'h0;
      far_rf_s2_ff <= 2'h0;
      fef_s1_ff    <= 1'b0;
      fef_s2_ff    <= 1'b0;
      fef_s3_ff    <= 1'b0;
      sd_s1_ff     <= 2'h0;
      sd_s2_ff     <= 2'h0;
      port_id_s1_ff <= PORT_ID_RST;
      port_id_s2_ff <= PORT_ID_RST;
    end else begin
      far_rf_s1_ff <= far_partner_remote_fault;
      far_rf_s2_ff <= far_rf_s1_ff;
      fef_s1_ff    <= far_end_fault;
      fef_s2_ff    <= fef_s1_ff;
      fef_s3_ff    <= fef_s2_ff;
      sd_s1_ff     <= signal_detect_input;
      sd_s2_ff     <= sd_s1_ff;
      port_id_s1_ff <= port_id;
      port_id_s2_ff <= port_id_s1_ff;
    end
  end

  logic fef_rise;
  assign fef_rise = fef_s2_ff && !fef_s3_ff;

  // ==========================================================================
  // APB decode. Side effects act once, on the first access edge; the second access cycle
  // only carries the registered answer, so a clear-on-read cannot swallow a fresh event.
  logic apb_wr, apb_rd;
  assign apb_wr = psel && penable && pwrite && !pready;
  assign apb_rd = psel && penable && !pwrite && !pready;

  function automatic logic known_offset(input logic [11:0] a);
    known_offset = (a == APB_MGMT_CMD) || (a == APB_MGMT_RDATA) || (a == APB_IRQ_STATUS) ||
                   (a == APB_IRQ_MASK) || (a == APB_LINK_STATUS);
  endfunction : known_offset

  // A management command word carries data in 15:0, the address in 20:16 and the write flag in 24.
  logic        mgmt_go;
  logic [4:0]  mgmt_addr;
  logic [15:0] mgmt_wdata;
  logic        mgmt_write;
  assign mgmt_go    = apb_wr && (paddr == APB_MGMT_CMD);
  assign mgmt_addr  = pwdata[20:16];
  assign mgmt_wdata = pwdata[15:0];
  assign mgmt_write = pwdata[24];

  // ==========================================================================
  // Page select register.
  logic [15:0] page_sel_ff;
  logic        page_one;
  assign page_one = (page_sel_ff == PAGE_EXT1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_sel_ff <= PAGE_MAIN;
    end else if (mgmt_go && mgmt_write && mgmt_addr == PAGE_SEL_ADDR) begin
      page_sel_ff <= mgmt_wdata;
    end
  end

  function automatic logic in_page_one(input logic [4:0] a, input logic p1);
    in_page_one = p1 && (a >= UPPER_FIRST) && (a <= UPPER_LAST);
  endfunction : in_page_one

  logic p1_hit, p1_read;
  assign p1_hit  = mgmt_go && in_page_one(mgmt_addr, page_one);
  assign p1_read = p1_hit && !mgmt_write;

  // ==========================================================================
  // Page-one control registers.
  logic [15:0] fiber_ctrl_ff, ext_mode_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fiber_ctrl_ff <= FIBER_CTRL_RST;
      ext_mode_ff   <= EXT_MODE_RST;
    end else if (p1_hit && mgmt_write) begin
      if (mgmt_addr == FIBER_CTRL_ADDR) begin
        fiber_ctrl_ff <= mgmt_wdata & FIBER_CTRL_WMASK;
      end
      if (mgmt_addr == EXT_MODE_ADDR) begin
        ext_mode_ff <= mgmt_wdata & EXT_MODE_WMASK;
      end
    end
  end

  // Far-end fault flag: a new fault beats the read that would clear it.
  logic fef_flag_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fef_flag_ff <= 1'b0;
    end else if (fef_rise) begin
      fef_flag_ff <= 1'b1;
    end else if (p1_read && mgmt_addr == FIBER_CTRL_ADDR) begin
      fef_flag_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Good-CRC counter. good_crc_packet is a one-cycle strobe from local logic.
  logic        crc_rd;
  logic        pkt_seen_ff;
  logic [13:0] crc_cnt_ff;
  logic        crc_wrap;
  assign crc_rd   = p1_read && (mgmt_addr == GOOD_CRC_ADDR);
  assign crc_wrap = good_crc_packet && (crc_cnt_ff == CRC_MODULUS_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_cnt_ff <= 14'h0;
    end else if (crc_rd) begin
      crc_cnt_ff <= good_crc_packet ? 14'h1 : 14'h0;
    end else if (good_crc_packet) begin
      crc_cnt_ff <= crc_wrap ? 14'h0 : crc_cnt_ff + 14'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_seen_ff <= 1'b0;
    end else if (good_crc_packet) begin
      pkt_seen_ff <= 1'b1;
    end else if (crc_rd) begin
      pkt_seen_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Management read data.
  logic [15:0] nxt_mgmt_rdata;
  logic [15:0] mgmt_rdata_ff;

  always_comb begin
    nxt_mgmt_rdata = 16'h0;
    if (mgmt_addr == PAGE_SEL_ADDR) begin
      nxt_mgmt_rdata = page_sel_ff;
    end else if (in_page_one(mgmt_addr, page_one)) begin
      unique case (mgmt_addr)
        FIBER_CTRL_ADDR: begin
          nxt_mgmt_rdata = fiber_ctrl_ff;
          nxt_mgmt_rdata[LP_RF_HI:LP_RF_LO] = far_rf_s2_ff;
          nxt_mgmt_rdata[FEF_BIT] = fef_flag_ff;
        end
        GOOD_CRC_ADDR: begin
          nxt_mgmt_rdata = {pkt_seen_ff, 1'b0, crc_cnt_ff};
        end
        EXT_MODE_ADDR: nxt_mgmt_rdata = ext_mode_ff;
        default:       nxt_mgmt_rdata = 16'h0;
      endcase
    end
  end

  // Standard-space read addresses are passed out so the main register file can answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_rdata_ff <= 16'h0;
      std_rdata_req <= 16'h0;
    end else if (mgmt_go && !mgmt_write) begin
      mgmt_rdata_ff <= nxt_mgmt_rdata;
      std_rdata_req <= {11'h0, mgmt_addr};
    end
  end

  // ==========================================================================
  // Interrupts: sticky status cleared by reading it; events win over the clear.
  logic [2:0] irq_stat_ff, irq_mask_ff, irq_evt;
  assign irq_evt = {crc_wrap, good_crc_packet, fef_rise};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= 3'h0;
    end else if (apb_rd && paddr == APB_IRQ_STATUS) begin
      irq_stat_ff <= irq_evt;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_ff <= 3'h0;
    end else if (apb_wr && paddr == APB_IRQ_MASK) begin
      irq_mask_ff <= pwdata[2:0];
    end
  end

  logic [2:0] nxt_irq_stat_view;
  assign nxt_irq_stat_view = (apb_rd && paddr == APB_IRQ_STATUS) ? irq_evt : (irq_stat_ff | irq_evt);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(nxt_irq_stat_view & irq_mask_ff);
    end
  end

  // ==========================================================================
  // Outputs towards the port logic.
  logic fiber_port;
  assign fiber_port = (32'(port_id_s2_ff) < FIBER_PORTS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg                <= '0;
      fiber_1000x_permit <= 1'b0;
      fiber_100fx_permit <= 1'b0;
      signal_detect_seen <= 2'h0;
    end else begin
      cfg.led_ext_mode      <= ext_mode_ff[LED_EXT_HI:LED_EXT_LO];
      cfg.reset_blink_en    <= ext_mode_ff[BLINK_BIT];
      cfg.fast_link_fail_en <= ext_mode_ff[FLF_BIT];
      cfg.crossover         <= pxp1_xover_t'(ext_mode_ff[XOVER_HI:XOVER_LO]);
      cfg.signal_detect_input_active_low <= ext_mode_ff[SIGNAL_DETECT_INPUT_POL_BIT];
      cfg.tx_remote_fault   <= fiber_port ? fiber_ctrl_ff[TX_RF_HI:TX_RF_LO] : 2'h0;
      cfg.allow_1000x       <= fiber_ctrl_ff[ALLOW_1000X_BIT];
      cfg.allow_100fx       <= fiber_ctrl_ff[ALLOW_100FX_BIT];
      fiber_1000x_permit    <= fiber_port && fiber_ctrl_ff[ALLOW_1000X_BIT];
      fiber_100fx_permit    <= fiber_port && fiber_ctrl_ff[ALLOW_100FX_BIT];
      signal_detect_seen    <= ext_mode_ff[SIGNAL_DETECT_INPUT_POL_BIT] ? ~sd_s2_ff : sd_s2_ff;
    end
  end

  // ==========================================================================
  // APB read mux and response.
  logic [31:0] nxt_prdata;
  always_comb begin
    nxt_prdata = 32'h0;
    unique case (paddr)
      APB_MGMT_RDATA:  nxt_prdata = {16'h0, mgmt_rdata_ff};
      APB_IRQ_STATUS:  nxt_prdata = {29'h0, irq_stat_ff};
      APB_IRQ_MASK:    nxt_prdata = {29'h0, irq_mask_ff};
      APB_LINK_STATUS: nxt_prdata = {28'h0, signal_detect_seen, fiber_1000x_permit, fiber_100fx_permit};
      default:         nxt_prdata = 32'h0;
    endcase
  end

  // Ready is registered, so each access phase lasts exactly two cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !known_offset(paddr);
      prdata  <= (psel && penable && !pready) ? nxt_prdata : 32'h0;
    end
  end

  // ==========================================================================
  // Checks.
  a_page_select_one: assert property (@(posedge pclk) disable iff (!presetn)
    (mgmt_go && mgmt_write && mgmt_addr == PAGE_SEL_ADDR && mgmt_wdata == PAGE_EXT1) |=> page_one)
    else $error("page one not selected");
  a_page_select_main: assert property (@(posedge pclk) disable iff (!presetn)
    (mgmt_go && mgmt_write && mgmt_addr == PAGE_SEL_ADDR && mgmt_wdata == PAGE_MAIN) |=> !page_one)
    else $error("main space not restored");
  a_low_addr_std: assert property (@(posedge pclk) disable iff (!presetn)
    (mgmt_go && mgmt_addr < UPPER_FIRST) |-> !p1_hit)
    else $error("low address went to page one");
  a_fef_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    fef_rise |=> fef_flag_ff)
    else $error("far end fault not captured");
  a_pkt_seen_set: assert property (@(posedge pclk) disable iff (!presetn)
    good_crc_packet |=> pkt_seen_ff)
    else $error("packet seen flag not set");
  a_crc_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (crc_wrap && !crc_rd) |=> crc_cnt_ff == 14'h0)
    else $error("counter did not wrap");
  a_crc_bound: assert property (@(posedge pclk) disable iff (!presetn)
    crc_cnt_ff <= CRC_MODULUS_LAST)
    else $error("counter beyond modulus");
  a_permit_port: assert property (@(posedge pclk) disable iff (!presetn)
    !fiber_port |=> !fiber_1000x_permit && !fiber_100fx_permit)
    else $error("fiber permit on non-fiber port");
  a_xover_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 cfg.crossover == $past(ext_mode_ff[XOVER_HI:XOVER_LO]))
    else $error("crossover mode mismatch");

  // ==========================================================================
  // Checks on clear-on-read, counting and register writes.
  a_fef_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (p1_read && mgmt_addr == FIBER_CTRL_ADDR && !fef_rise) |=> !fef_flag_ff)
    else $error("far end fault flag not cleared by read");
  a_crc_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (crc_rd && !good_crc_packet) |=> !pkt_seen_ff && crc_cnt_ff == 14'h0)
    else $error("good packet register not cleared by read");
  a_crc_step: assert property (@(posedge pclk) disable iff (!presetn)
    (good_crc_packet && !crc_rd && !crc_wrap) |=> crc_cnt_ff == $past(crc_cnt_ff) + 14'h1)
    else $error("counter did not step by one");
  a_fiber_write: assert property (@(posedge pclk) disable iff (!presetn)
    (p1_hit && mgmt_write && mgmt_addr == FIBER_CTRL_ADDR) |=> fiber_ctrl_ff == ($past(mgmt_wdata) & FIBER_CTRL_WMASK))
    else $error("fiber control write lost");
  a_page_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (page_one && !(mgmt_go && mgmt_write && mgmt_addr == PAGE_SEL_ADDR)) |=> page_one)
    else $error("page one dropped without a write");

  // ==========================================================================
  // Checks on the port-facing outputs and the bus answer.
  a_permit_follow: assert property (@(posedge pclk) disable iff (!presetn)
    fiber_port |=> {fiber_1000x_permit, fiber_100fx_permit} == $past(fiber_ctrl_ff[ALLOW_1000X_BIT:ALLOW_100FX_BIT]))
    else $error("fiber permit does not follow its bit");
  a_remote_fault_port: assert property (@(posedge pclk) disable iff (!presetn)
    !fiber_port |=> cfg.tx_remote_fault == 2'h0)
    else $error("remote fault sent on non-fiber port");
  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_error_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response without ready");
  c_page_one_write: cover property (@(posedge pclk) p1_hit && mgmt_write);
  c_fef_event: cover property (@(posedge pclk) fef_rise);
  c_port_off: cover property (@(posedge pclk) !fiber_port);
  c_crc_wrap: cover property (@(posedge pclk) crc_wrap);
  c_irq_raise: cover property (@(posedge pclk) !irq ##1 irq);

endmodule : pxp1_regs

// ===== dv/pxp1_far_model.sv
`timescale 1ns/1ps
// ============================================================================
// Far side of the block: copper receiver, fiber negotiation partner and detect pins.
module pxp1_far_model (
  input  wire logic       pclk,
  output logic [1:0]      far_partner_remote_fault,
  output logic            far_end_fault,
  output logic            good_crc_packet,
  output logic [1:0]      signal_detect_input
);
  initial begin
    far_partner_remote_fault = 2'h0;
    far_end_fault            = 1'b0;
    good_crc_packet          = 1'b0;
    signal_detect_input      = 2'h0;
  end

  // A gap cycle separates packets so that each pulse is one packet.
  task automatic pkts(input int n);
    repeat (n) begin
      @(posedge pclk) good_crc_packet <= 1'b1;
      @(posedge pclk) good_crc_packet <= 1'b0;
    end
  endtask : pkts

  // The level is held well past the two-flop synchroniser before it drops.
  task automatic fault();
    @(posedge pclk) far_end_fault <= 1'b1;
    repeat (6) @(posedge pclk);
    far_end_fault <= 1'b0;
  endtask : fault

  task automatic set_pins(input logic [1:0] rf, input logic [1:0] sd);
    @(posedge pclk) far_partner_remote_fault <= rf;
    signal_detect_input <= sd;
  endtask : set_pins
endmodule : pxp1_far_model

// ===== dv/phy_ext_page1_regs_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module phy_ext_page1_regs_tb;
  import pxp1_pkg::*;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [2:0]          port_id;
  logic [1:0]          rf;
  logic                fef;
  logic                gcp;
  logic [1:0]          sdi;
  logic [1:0]          sd_seen;
  pxp1_cfg_t           cfg;
  logic [15:0]         std_req;
  logic                p1000;
  logic                p100;
  logic                irq;
  int                  miscompares;
  int                  checks;
  logic [15:0]         d;
  logic [31:0]         r;
  logic                e;
  logic [1:0]          m;

  pxp1_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_id(port_id),
    .far_partner_remote_fault(rf), .far_end_fault(fef), .good_crc_packet(gcp), .signal_detect_input(sdi),
    .signal_detect_seen(sd_seen), .cfg(cfg), .std_rdata_req(std_req), .fiber_1000x_permit(p1000),
    .fiber_100fx_permit(p100), .irq(irq));

  pxp1_far_model far (.pclk(pclk), .far_partner_remote_fault(rf), .far_end_fault(fef),
    .good_crc_packet(gcp), .signal_detect_input(sdi));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ==========================================================================
  // Bus access tasks.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic mw(input logic [4:0] a, input logic [15:0] wd);
    logic [31:0] x;
    logic        y;
    apb(1'b1, APB_MGMT_CMD, {7'h0, 1'b1, 3'h0, a, wd}, x, y);
  endtask : mw

  task automatic mr(input logic [4:0] a, output logic [15:0] rd);
    logic [31:0] x;
    logic        y;
    apb(1'b1, APB_MGMT_CMD, {11'h0, a, 16'h0}, x, y);
    apb(1'b0, APB_MGMT_RDATA, 32'h0, x, y);
    rd = x[15:0];
  endtask : mr

  task automatic tend(input string name);
    $display("test %s finished, mismatches so far %0d", name, miscompares);
  endtask : tend

  task automatic test_done();
    $display("checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // A hung wait is cut short long after the longest test should end.
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    test_done();
  end

  // ==========================================================================
  // Test sequence.
  initial begin
    miscompares = 0;
    checks      = 0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    port_id     = 3'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK({p1000, p100}, 2'b11);
    mw(5'h1f, 16'h0001);
    mr(5'h10, d);
    `CHK(d, 16'h0300);
    mr(5'h13, d);
    `CHK(d, 16'h0000);
    mr(5'h12, d);
    `CHK(d, 16'h0000);
    mr(5'h00, d);
    `CHK({std_req, d}, 32'h0);
    tend("reset");

    far.set_pins(2'b10, 2'b01);
    mw(5'h10, 16'hffff);
    mr(5'h10, d);
    `CHK(d, 16'he300);
    `CHK(cfg.tx_remote_fault, 2'b11);
    mw(5'h10, 16'h0000);
    mr(5'h10, d);
    `CHK(d, 16'h2000);
    `CHK({p1000, p100}, 2'b00);
    far.fault();
    mr(5'h10, d);
    `CHK(d[6], 1'b1);
    mr(5'h10, d);
    `CHK(d[6], 1'b0);
    tend("fiber");

    mw(5'h1f, 16'h0000);
    mw(5'h10, 16'hc300);
    mr(5'h10, d);
    `CHK({std_req, d}, {16'h0010, 16'h0000});
    mw(5'h1f, 16'h0001);
    mr(5'h10, d);
    `CHK(d, 16'h2000);
    tend("paging");

    far.pkts(3);
    mr(5'h12, d);
    `CHK(d, 16'h8003);
    mr(5'h12, d);
    `CHK(d, 16'h0000);
    far.pkts(10000);
    mr(5'h12, d);
    `CHK(d, 16'h8000);
    tend("counter");

    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      mw(5'h13, {12'hfff, m, 2'b11});
      mr(5'h13, d);
      `CHK(d, {5'h1f, 6'h00, 1'b1, m, 1'b0, 1'b1});
      `CHK(cfg.crossover, pxp1_xover_t'(m));
    end
    `CHK({cfg.led_ext_mode, cfg.reset_blink_en, cfg.fast_link_fail_en}, 6'h3f);
    `CHK(sd_seen, 2'b10);
    mw(5'h13, 16'h0000);
    mr(5'h13, d);
    `CHK(sd_seen, 2'b01);
    apb(1'b0, APB_LINK_STATUS, 32'h0, r, e);
    `CHK({e, r[3:0]}, 5'b00100);
    tend("mode");

    apb(1'b0, 12'h020, 32'h0, r, e);
    `CHK({e, r}, {1'b1, 32'h0});
    apb(1'b0, APB_IRQ_STATUS, 32'h0, r, e);
    `CHK(r[2:0], 3'b111);
    apb(1'b1, APB_IRQ_MASK, 32'h0, r, e);
    far.pkts(1);
    repeat (4) @(posedge pclk);
    `CHK(irq, 1'b0);
    apb(1'b0, APB_IRQ_STATUS, 32'h0, r, e);
    `CHK(r[2:0], 3'b010);
    apb(1'b1, APB_IRQ_MASK, 32'h2, r, e);
    apb(1'b0, APB_IRQ_MASK, 32'h0, r, e);
    `CHK(r[2:0], 3'b010);
    far.pkts(1);
    repeat (4) @(posedge pclk);
    `CHK(irq, 1'b1);
    apb(1'b0, APB_IRQ_STATUS, 32'h0, r, e);
    `CHK(r[2:0], 3'b010);
    repeat (4) @(posedge pclk);
    `CHK(irq, 1'b0);
    tend("interrupt");

    mw(5'h10, 16'hc300);
    port_id <= 3'h4;
    repeat (4) @(posedge pclk);
    `CHK({p1000, p100, cfg.tx_remote_fault}, 4'b0000);
    `CHK({cfg.allow_1000x, cfg.allow_100fx}, 2'b11);
    port_id <= 3'h0;
    repeat (4) @(posedge pclk);
    `CHK({p1000, p100, cfg.tx_remote_fault}, 4'b1111);
    tend("ports");

    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    mr(5'h10, d);
    `CHK(d, 16'h0000);
    mw(5'h1f, 16'h0001);
    mr(5'h10, d);
    `CHK(d, 16'h2300);
    tend("reset again");
    test_done();
  end
endmodule : phy_ext_page1_regs_tb
